// File: rtl/ext_reg_pkg.sv
// Package: register map, field positions, reset values and mode codes
package ext_reg_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] mode_control_off      = 8'h00;
   localparam logic [7:0] hardware_control_off  = 8'h04;
   localparam logic [7:0] supply_status_off     = 8'h08;
   localparam logic [7:0] fail_status_off       = 8'h0C;
   localparam logic [7:0] regulator_state_off   = 8'h10;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int standalone_enable_bit     = 0;
   localparam int output_voltage_select_bit = 1;
   localparam int load_share_enable_bit     = 0;
   localparam int undervoltage_keep_on_bit  = 1;
   localparam int stop_keep_load_share_bit  = 2;
   localparam int overcurrent_flag_bit      = 0;
   localparam int undervoltage_flag_bit     = 1;
   localparam int spi_fail_bit              = 0;
   // State register: on, lock, load_share, high_power, low_power, volt_1v8
   localparam int state_on_bit     = 0;
   localparam int state_locked_bit = 1;
   localparam int state_ls_bit     = 2;
   localparam int state_hp_bit     = 3;
   localparam int state_lp_bit     = 4;
   localparam int state_1v8_bit    = 5;
   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] reg_reset = 32'h0000_0000;
   // ------------------------------------------------------------
   // System modes, one-hot
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      mode_init      = 6'b00_0001,
      mode_normal    = 6'b00_0010,
      mode_stop      = 6'b00_0100,
      mode_sleep     = 6'b00_1000,
      mode_restart   = 6'b01_0000,
      mode_fail_safe = 6'b10_0000
   } sys_mode_t;
   // Configuration states, one-hot
   typedef enum logic [2:0] {
      cfg_none       = 3'b001,
      cfg_standalone = 3'b010,
      cfg_load_share = 3'b100
   } cfg_t;
endpackage

// File: rtl/sync2.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module sync2 #(
   parameter int width = 1
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Data
   input  wire logic [width-1:0] async_in,
   output logic      [width-1:0] sync_out
);
   typedef struct packed {
      logic [width-1:0] meta;
      logic [width-1:0] stable;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   always_comb begin
      s_d.meta   = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.stable;
endmodule

// File: rtl/ext_regulator_config_control.sv
// Configuration, lock and enable control for the external third regulator
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
module ext_regulator_config_control (
   // Clock and resets
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        soft_reset,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // System mode from mode machine
   input  wire logic [5:0]  system_mode,
   // Analog comparators, asynchronous
   input  wire logic        battery_undervoltage_threshold,
   input  wire logic        shunt_threshold_reached,
   input  wire logic        regulator_undervoltage,
   input  wire logic        base_current_peak,
   // Regulator controls
   output logic             third_regulator_on,
   output logic             high_power_stage_on,
   output logic             low_power_stage_on,
   output logic             output_voltage_1v8,
   output logic             current_limit_active
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      ext_reg_pkg::cfg_t cfg;
      logic              standalone_enable;
      logic              output_voltage_select;
      logic              load_share_enable;
      logic              undervoltage_keep_on;
      logic              stop_keep_load_share;
      logic              overcurrent_flag;
      logic              undervoltage_flag;
      logic              spi_fail;
      logic              reg_on;
      logic              hp_on;
      logic              lp_on;
      logic              v1v8;
      logic [31:0]       rdata;
      // High in the cycle in which registered read data stands
      logic              rd_done;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [3:0] ana_sync;
   logic       bat_uv;
   logic       shunt_hit;
   logic       reg_uv;
   logic       peak_hi;
   // Read answer comes from a flop, never from the live request
   logic       rd_ready;

   sync2 #(
      .width (4)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({base_current_peak, regulator_undervoltage,
                  shunt_threshold_reached, battery_undervoltage_threshold}),
      .sync_out (ana_sync)
   );

   assign bat_uv    = ana_sync[0];
   assign shunt_hit = ana_sync[1];
   assign reg_uv    = ana_sync[2];
   assign peak_hi   = ana_sync[3];

   logic wr_en;
   logic rd_en;
   logic mapped;
   logic is_sa;
   logic is_ls;
   logic in_normal;
   logic in_stop;
   logic in_sleep;
   logic in_restart;
   logic want_on;

   always_comb begin
      wr_en      = psel && penable && pwrite;
      rd_en      = psel && penable && !pwrite;
      is_sa      = (s_q.cfg == ext_reg_pkg::cfg_standalone);
      is_ls      = (s_q.cfg == ext_reg_pkg::cfg_load_share);
      in_normal  = (system_mode == ext_reg_pkg::mode_normal);
      in_stop    = (system_mode == ext_reg_pkg::mode_stop);
      in_sleep   = (system_mode == ext_reg_pkg::mode_sleep);
      in_restart = (system_mode == ext_reg_pkg::mode_restart);
      mapped     = (paddr == ext_reg_pkg::mode_control_off) || (paddr == ext_reg_pkg::hardware_control_off) ||
                   (paddr == ext_reg_pkg::supply_status_off) || (paddr == ext_reg_pkg::fail_status_off) ||
                   (paddr == ext_reg_pkg::regulator_state_off);
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_d     = s_q;
      want_on = 1'b0;
      // Soft reset clears control bits but never the configuration lock
      if (soft_reset) begin
         s_d.standalone_enable     = 1'b0;
         s_d.output_voltage_select = 1'b0;
         s_d.undervoltage_keep_on  = 1'b0;
         s_d.stop_keep_load_share  = 1'b0;
         s_d.spi_fail              = 1'b0;
         s_d.load_share_enable     = is_ls;
      end
      if (wr_en) begin
         case (paddr)
            ext_reg_pkg::mode_control_off: begin
               s_d.output_voltage_select = pwdata[ext_reg_pkg::output_voltage_select_bit];
               if (is_ls) begin
                  // Enable bit enables nothing once load sharing is locked; writing it as one sets spi_fail
                  if (pwdata[ext_reg_pkg::standalone_enable_bit]) begin
                     s_d.spi_fail = 1'b1;
                  end
               end else if (in_normal) begin
                  s_d.standalone_enable = pwdata[ext_reg_pkg::standalone_enable_bit];
                  if (s_q.cfg == ext_reg_pkg::cfg_none && pwdata[ext_reg_pkg::standalone_enable_bit]) begin
                     s_d.cfg = ext_reg_pkg::cfg_standalone;
                  end
               end
            end
            ext_reg_pkg::hardware_control_off: begin
               s_d.undervoltage_keep_on = pwdata[ext_reg_pkg::undervoltage_keep_on_bit];
               s_d.stop_keep_load_share = pwdata[ext_reg_pkg::stop_keep_load_share_bit];
               if (s_q.cfg == ext_reg_pkg::cfg_none && pwdata[ext_reg_pkg::load_share_enable_bit]) begin
                  s_d.cfg               = ext_reg_pkg::cfg_load_share;
                  s_d.load_share_enable = 1'b1;
                  s_d.standalone_enable = 1'b0;
               end else if (is_ls && !pwdata[ext_reg_pkg::load_share_enable_bit]) begin
                  s_d.spi_fail = 1'b1;
               end
               // Standalone: load-share write silently dropped
            end
            ext_reg_pkg::supply_status_off: begin
               // Write one to clear; refused while condition persists
               if (pwdata[ext_reg_pkg::overcurrent_flag_bit] && !shunt_hit) begin
                  s_d.overcurrent_flag = 1'b0;
               end
               if (pwdata[ext_reg_pkg::undervoltage_flag_bit]) begin
                  s_d.undervoltage_flag = 1'b0;
               end
            end
            ext_reg_pkg::fail_status_off: begin
               if (pwdata[ext_reg_pkg::spi_fail_bit]) begin
                  s_d.spi_fail = 1'b0;
               end
            end
            default: begin
               s_d.spi_fail = s_d.spi_fail;
            end
         endcase
      end
      // Hardware sets win over a clear in the same cycle
      if (wr_en && is_ls && paddr == ext_reg_pkg::mode_control_off && pwdata[ext_reg_pkg::standalone_enable_bit]) begin
         s_d.spi_fail = 1'b1;
      end
      if (is_sa && shunt_hit) begin
         s_d.overcurrent_flag = 1'b1;
      end
      if (is_sa && reg_uv) begin
         s_d.undervoltage_flag = 1'b1;
      end
      if (is_ls) begin
         s_d.overcurrent_flag  = 1'b0;
         s_d.undervoltage_flag = 1'b0;
      end
      // Mode-dependent enable
      if (is_sa) begin
         if (in_normal) begin
            want_on = s_d.standalone_enable;
         end else if (in_stop || in_sleep || in_restart) begin
            want_on = s_q.reg_on;
         end else begin
            want_on = 1'b0;
         end
      end else if (is_ls) begin
         if (in_normal || in_restart) begin
            want_on = s_q.load_share_enable;
         end else if (in_stop) begin
            want_on = s_q.load_share_enable && s_q.stop_keep_load_share;
         end else begin
            want_on = 1'b0;
         end
      end
      // Fixed states hold the commanded level, undervoltage gating applies on top
      if (is_sa && !in_normal && (in_stop || in_sleep || in_restart)) begin
         s_d.reg_on = want_on;
      end else begin
         s_d.reg_on = want_on;
      end
      s_d.hp_on = 1'b0;
      s_d.lp_on = 1'b0;
      if (want_on) begin
         if (in_normal) begin
            s_d.hp_on = 1'b1;
         end else begin
            s_d.lp_on = 1'b1;
            s_d.hp_on = peak_hi;
         end
      end
      s_d.v1v8 = is_sa && s_d.output_voltage_select;
      s_d.rdata = 32'h0000_0000;
      if (rd_en) begin
         case (paddr)
            ext_reg_pkg::mode_control_off: begin
               s_d.rdata[ext_reg_pkg::standalone_enable_bit]     = s_q.standalone_enable;
               s_d.rdata[ext_reg_pkg::output_voltage_select_bit] = s_q.output_voltage_select;
            end
            ext_reg_pkg::hardware_control_off: begin
               s_d.rdata[ext_reg_pkg::load_share_enable_bit]    = s_q.load_share_enable;
               s_d.rdata[ext_reg_pkg::undervoltage_keep_on_bit] = s_q.undervoltage_keep_on;
               s_d.rdata[ext_reg_pkg::stop_keep_load_share_bit] = s_q.stop_keep_load_share;
            end
            ext_reg_pkg::supply_status_off: begin
               s_d.rdata[ext_reg_pkg::overcurrent_flag_bit]  = s_q.overcurrent_flag;
               s_d.rdata[ext_reg_pkg::undervoltage_flag_bit] = s_q.undervoltage_flag;
            end
            ext_reg_pkg::fail_status_off: begin
               s_d.rdata[ext_reg_pkg::spi_fail_bit] = s_q.spi_fail;
            end
            ext_reg_pkg::regulator_state_off: begin
               s_d.rdata[ext_reg_pkg::state_on_bit]     = s_q.reg_on && !(bat_uv && !s_q.undervoltage_keep_on);
               s_d.rdata[ext_reg_pkg::state_locked_bit] = (s_q.cfg != ext_reg_pkg::cfg_none);
               s_d.rdata[ext_reg_pkg::state_ls_bit]     = is_ls;
               s_d.rdata[ext_reg_pkg::state_hp_bit]     = s_q.hp_on;
               s_d.rdata[ext_reg_pkg::state_lp_bit]     = s_q.lp_on;
               s_d.rdata[ext_reg_pkg::state_1v8_bit]    = s_q.v1v8;
            end
            default: begin
               s_d.rdata = 32'h0000_0000;
            end
         endcase
      end
      // One wait state per read, cleared again once the answer is taken
      s_d.rd_done = rd_en && !s_q.rd_done;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q       <= '0;
         s_q.cfg   <= ext_reg_pkg::cfg_none;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Battery undervoltage gate is combinational so recovery needs no software
   assign third_regulator_on   = s_q.reg_on && !(bat_uv && !s_q.undervoltage_keep_on);
   // Stages follow the gated enable so neither runs while the regulator is off
   assign high_power_stage_on  = s_q.hp_on && third_regulator_on;
   assign low_power_stage_on   = s_q.lp_on && third_regulator_on;
   assign output_voltage_1v8   = s_q.v1v8;
   assign current_limit_active = is_sa && shunt_hit;
   assign prdata               = s_q.rdata;
   // ------------------------------------------------------------
   // APB response
   // ------------------------------------------------------------
   // Writes complete in the first access cycle; read data is registered,
   // so a read answers one cycle later, when the captured word stands
   assign rd_ready = s_q.rd_done;
   assign pready   = psel && penable && (pwrite || rd_ready);
   // Unmapped offsets still complete, with an error response
   assign pslverr  = psel && penable && pready && !mapped;
endmodule

// File: testbench/ext_reg_monitor.sv
// Checker: port-level properties of the third regulator control block
`timescale 1ns/100ps
module ext_reg_monitor (
   // Clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // APB
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pwrite,
   input wire logic       pready,
   input wire logic       pslverr,
   // Mode and regulator controls
   input wire logic [5:0] system_mode,
   input wire logic       third_regulator_on,
   input wire logic       high_power_stage_on,
   input wire logic       low_power_stage_on,
   input wire logic       output_voltage_1v8
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   logic [2:0] since_wr_q;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Four cycles leaves room for output registering
   sequence held(m);
      (system_mode == m)[*4];
   endsequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since_wr_q <= 3'h7;
      else if (psel && penable && pwrite && pready) since_wr_q <= 3'h0;
      else if (since_wr_q != 3'h7) since_wr_q <= since_wr_q + 3'h1;
   end
   apb_answer_a: assert property (psel && penable |-> ##[0:16] pready)
      else $error("APB access not answered");
   err_ready_a: assert property (pslverr |-> pready) else $error("Error response without ready");
   init_off_a: assert property (held(ext_reg_pkg::mode_init) |-> !third_regulator_on)
      else $error("Regulator on in init mode");
   fail_off_a: assert property (held(ext_reg_pkg::mode_fail_safe) |-> !third_regulator_on)
      else $error("Regulator on in fail-safe mode");
   fail_stage_a: assert property (held(ext_reg_pkg::mode_fail_safe) |-> !high_power_stage_on)
      else $error("Power stage on in fail-safe mode");
   normal_lp_a: assert property (held(ext_reg_pkg::mode_normal) |-> !low_power_stage_on)
      else $error("Low-power stage on in normal mode");
   normal_hp_a: assert property ((system_mode == ext_reg_pkg::mode_normal && third_regulator_on)[*4]
      |-> high_power_stage_on) else $error("High-power stage off in normal mode");
   mode_rise_a: assert property ($rose(third_regulator_on) |-> !(system_mode inside
      {ext_reg_pkg::mode_init, ext_reg_pkg::mode_fail_safe})) else $error("Regulator rose in off mode");
   vsel_rise_a: assert property ($rose(output_voltage_1v8) |-> since_wr_q < 3'h5)
      else $error("Voltage select changed without a write");
endmodule
bind ext_regulator_config_control ext_reg_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
   .pslverr, .system_mode, .third_regulator_on, .high_power_stage_on, .low_power_stage_on, .output_voltage_1v8);

// File: testbench/host_apb_model.sv
// Host model: APB master that programs the regulator control block
`timescale 1ns/100ps
module host_apb_model (
   // Clock
   input  wire logic        pclk,
   // APB master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready
);
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // Request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // No cycle count assumed: only the bench watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      r = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
      // Released data does not keep its last value
      pwdata <= ~d;
   endtask
endmodule

// File: testbench/ext_regulator_config_control_bench.sv
// Testbench: configuration lock, mode behaviour and flags of the regulator control
`timescale 1ns/100ps
module ext_regulator_config_control_bench;
   logic pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr;
   logic bat_uv, shunt, reg_uv, peak, reg_on, hp_on, lp_on, v18, climit;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [5:0]  system_mode;
   int          n_fail, checks, cfg, sa_en, vsel, uv_keep, stp_keep, bat;
   ext_reg_pkg::sys_mode_t ml [6] = '{ext_reg_pkg::mode_stop, ext_reg_pkg::mode_sleep,
      ext_reg_pkg::mode_restart, ext_reg_pkg::mode_fail_safe, ext_reg_pkg::mode_init, ext_reg_pkg::mode_normal};
   ext_regulator_config_control dut (.pclk, .presetn, .soft_reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .system_mode, .battery_undervoltage_threshold(bat_uv),
      .shunt_threshold_reached(shunt), .regulator_undervoltage(reg_uv), .base_current_peak(peak),
      .third_regulator_on(reg_on), .high_power_stage_on(hp_on), .low_power_stage_on(lp_on),
      .output_voltage_1v8(v18), .current_limit_active(climit));
   host_apb_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
   // ------------------------------------------------------------
   // Clock, model and tasks
   // ------------------------------------------------------------
   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end
   function automatic logic exp_on();
      if (cfg == 0 || system_mode inside {ext_reg_pkg::mode_init, ext_reg_pkg::mode_fail_safe}) return 1'h0;
      if (bat != 0 && uv_keep == 0) return 1'h0;
      if (cfg == 1) return sa_en != 0;
      if (system_mode == ext_reg_pkg::mode_stop) return stp_keep != 0;
      return system_mode != ext_reg_pkg::mode_sleep;
   endfunction
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'h1, a, d, rd_v);
   endtask
   task rd(input logic [7:0] a);
      host.xfer(1'h0, a, 32'h0000_0000, rd_v);
   endtask
   // Random comparator noise on the base current input
   task settle(input string what);
      repeat (6) begin
         @(posedge pclk);
         peak <= 1'($urandom);
      end
      chk(what, {31'h0, exp_on()}, {31'h0, reg_on});
      rd(ext_reg_pkg::regulator_state_off);
      chk(what, {29'h0, cfg == 2, cfg != 0, exp_on()}, {29'h0, rd_v[2:0]});
      if (system_mode == ext_reg_pkg::mode_normal && exp_on()) begin
         chk("hp", 32'h0000_0001, {31'h0, hp_on});
         chk("v18", {31'h0, cfg == 1 && vsel == 1}, {31'h0, v18});
      end else if (exp_on()) begin
         chk("lp", 32'h0000_0001, {31'h0, lp_on});
      end
   endtask
   task walk;
      foreach (ml[i]) begin
         system_mode <= ml[i];
         settle("mode");
      end
   endtask
   task por;
      presetn <= 1'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
      {cfg, sa_en, vsel, uv_keep, stp_keep} = '0;
   endtask
   task flags(input logic [31:0] exp);
      shunt <= 1'h1;
      reg_uv <= 1'h1;
      repeat (6) @(posedge pclk);
      // Clear attempt while the conditions persist must not take
      wr(ext_reg_pkg::supply_status_off, 32'h0000_0003);
      rd(ext_reg_pkg::supply_status_off);
      chk("flags", exp, rd_v);
      chk("limit", {31'h0, cfg == 1}, {31'h0, climit});
      shunt <= 1'h0;
      reg_uv <= 1'h0;
      repeat (4) @(posedge pclk);
      wr(ext_reg_pkg::supply_status_off, 32'h0000_0003);
      rd(ext_reg_pkg::supply_status_off);
      chk("flags_clr", 32'h0000_0000, rd_v);
   endtask
   initial begin
      {presetn, soft_reset, bat_uv, shunt, reg_uv, peak, n_fail, checks, bat} = '0;
      system_mode = ext_reg_pkg::mode_init;
      void'($urandom(32'h30d2));
      por();
      for (int i = 0; i < 5; i++) begin
         rd(8'(4 * i));
         chk("reset", ext_reg_pkg::reg_reset, rd_v);
         chk("slverr", 32'h0000_0000, {31'h0, pslverr});
      end
      wr(8'h40, 32'h0000_0003);
      chk("slverr", 32'h0000_0001, {31'h0, pslverr});
      system_mode <= ext_reg_pkg::mode_normal;
      wr(ext_reg_pkg::mode_control_off, 32'h0000_0003);
      {cfg, sa_en, vsel} = {32'd1, 32'd1, 32'd1};
      settle("sa_on");
      wr(ext_reg_pkg::hardware_control_off, 32'h0000_0001);
      settle("sa_lock");
      rd(ext_reg_pkg::fail_status_off);
      chk("no_fail", 32'h0000_0000, rd_v);
      wr(ext_reg_pkg::mode_control_off, 32'h0000_0000);
      sa_en = 0;
      settle("sa_off");
      soft_reset <= 1'h1;
      @(posedge pclk);
      soft_reset <= 1'h0;
      wr(ext_reg_pkg::mode_control_off, 32'h0000_0001);
      {sa_en, vsel} = {32'd1, 32'd0};
      settle("soft");
      bat_uv <= 1'h1;
      bat = 1;
      settle("bat_off");
      bat_uv <= 1'h0;
      bat = 0;
      settle("bat_back");
      wr(ext_reg_pkg::hardware_control_off, 32'h0000_0002);
      uv_keep = 1;
      bat_uv <= 1'h1;
      bat = 1;
      settle("bat_keep");
      bat_uv <= 1'h0;
      bat = 0;
      flags(32'h0000_0003);
      walk();
      por();
      system_mode <= ext_reg_pkg::mode_normal;
      wr(ext_reg_pkg::hardware_control_off, 32'h0000_0001);
      cfg = 2;
      settle("ls_on");
      wr(ext_reg_pkg::mode_control_off, 32'h0000_0003);
      settle("ls_lock");
      rd(ext_reg_pkg::fail_status_off);
      chk("spi_fail", 32'h0000_0001, rd_v);
      flags(32'h0000_0000);
      walk();
      wr(ext_reg_pkg::hardware_control_off, 32'h0000_0005);
      stp_keep = 1;
      system_mode <= ext_reg_pkg::mode_stop;
      settle("stop_keep");
      final_report();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      final_report();
   end
endmodule
